/* File: rtl/gptu_pkg.sv */
// Package for the general purpose timer unit: offsets, fields, reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package gptu_pkg;
    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned M1_RES_NS = 400;
    localparam int unsigned M2_RES_NS = 200;
    localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
    localparam int unsigned M1_BASE_DIV = (M1_RES_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned M2_BASE_DIV = (M2_RES_NS + CLK_NS - 1) / CLK_NS;

    // ========================================================================
    // Register byte offsets
    // ========================================================================
    localparam logic [7:0] OFS_CTL_A = 8'h00;
    localparam logic [7:0] OFS_CTL_C = 8'h04;
    localparam logic [7:0] OFS_CTL_B = 8'h08;
    localparam logic [7:0] OFS_CTL_S = 8'h0c;
    localparam logic [7:0] OFS_CTL_T = 8'h10;
    localparam logic [7:0] OFS_CNT_A = 8'h14;
    localparam logic [7:0] OFS_CNT_C = 8'h18;
    localparam logic [7:0] OFS_CNT_B = 8'h1c;
    localparam logic [7:0] OFS_CNT_S = 8'h20;
    localparam logic [7:0] OFS_CNT_T = 8'h24;
    localparam logic [7:0] OFS_CAPTURE_RELOAD_REG = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_MASK = 8'h30;

    // ========================================================================
    // Timer control fields (same layout for all five timers)
    // ========================================================================
    localparam int F_PRE_LO = 0;    // prescaler exponent, 3 bits
    localparam int F_MODE_LO = 3;   // mode, 3 bits
    localparam int F_RUN = 6;
    localparam int F_DOWN = 7;
    localparam int F_EXTDIR = 8;    // direction pin may flip direction
    localparam int F_GATE_HI = 9;   // gate active level
    localparam int F_EDGE_LO = 10;  // 2 bits: event edge select
    localparam int F_OUT_EN = 12;   // toggle latch to pin
    localparam int F_REL_LO = 13;   // core: reload by latch rise/fall enables
    localparam int F_CLR_S = 15;    // module two: clear after capture
    localparam int CTL_W = 16;

    // Modes (3-bit encoding)
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_COUNT = 3'h1;
    localparam logic [2:0] MODE_GATE = 3'h2;
    localparam logic [2:0] MODE_CHAIN = 3'h3;   // clocked by partner toggle latch
    localparam logic [2:0] MODE_RELOAD = 3'h4;
    localparam logic [2:0] MODE_CAPTURE = 3'h5;

    // Status bits
    localparam int ST_A = 0;
    localparam int ST_C = 1;
    localparam int ST_B = 2;
    localparam int ST_S = 3;
    localparam int ST_T = 4;
    localparam int ST_CR = 5;
    localparam int ST_W = 6;

    localparam logic [15:0] CTL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
endpackage : gptu_pkg

/* File: rtl/gptu_counter.sv */
// One 16-bit up/down timer with load port and wrap event.
// Assumes the count enable is a single-cycle pulse in the clk_i domain.
`timescale 1ns/1ps
module gptu_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Count control
    input wire logic inc_i,
    input wire logic down_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    // State
    output logic [W-1:0] count_o,
    output logic wrap_o
);
    // ========================================================================
    // Counter
    // ========================================================================
    // Wrap is combinational so a reload can replace the wrapped value at once
    assign wrap_o = inc_i && (down_i ? (count_o == '0) : (count_o == '1));

    // Load has priority so software and reload writes are never lost to a count step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (inc_i) begin
            count_o <= down_i ? count_o - 1'b1 : count_o + 1'b1;
        end
    end
endmodule : gptu_counter

/* File: rtl/gptu_top.sv */
// Two-module general purpose timer unit behind a classic Wishbone slave.
// Assumes timer pins are synchronous to clk_i and already debounced.
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

module gptu_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timer pins, index 0..4 = aux a, core, aux b, second aux, base
    input wire logic [4:0] timer_input_pin_i,
    input wire logic [4:0] direction_input_pin_i,
    input wire logic capture_input_pin_i,
    output logic core_toggle_output_pin_o,
    output logic auxb_toggle_output_pin_o,
    output logic base_toggle_output_pin_o,
    // Feed to the capture/compare timers
    output logic capcom_clock_o,
    // Interrupt
    output logic irq_o
);
    import gptu_pkg::*;

    // ========================================================================
    // Registers and state
    // ========================================================================
    logic [CTL_W-1:0] ctl [5];
    logic [15:0] cnt [5];
    logic [4:0] inc;
    logic [4:0] ld;
    logic [15:0] ld_val [5];
    logic [4:0] wrap;
    logic [4:0] down;
    logic [4:0] pin_q;
    logic [4:0] pin_ev;
    logic [4:0] pin_rise;
    logic [4:0] pin_fall;
    logic [15:0] capture_reload_reg;
    logic cap_q;
    logic cap_ev;
    logic core_toggle_latch;
    logic auxb_toggle_latch;
    logic base_toggle_latch;
    logic core_tl_q;
    logic auxb_tl_q;
    logic base_tl_q;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [ST_W-1:0] ev;
    logic [15:0] pre_cnt;
    logic [15:0] next_pre_cnt;
    logic m1_tick;
    logic m2_tick;
    logic [7:0] m1_div;
    logic [7:0] m2_div;
    logic wb_req;
    logic wb_wr;
    logic [31:0] wdat;

    // ========================================================================
    // Base prescalers
    // ========================================================================
    // Base ticks at the finest period of each module
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m1_div <= 8'h00;
            m2_div <= 8'h00;
        end else begin
            m1_div <= (m1_div == 8'(M1_BASE_DIV - 1)) ? 8'h00 : m1_div + 8'h01;
            m2_div <= (m2_div == 8'(M2_BASE_DIV - 1)) ? 8'h00 : m2_div + 8'h01;
        end
    end
    assign m1_tick = (m1_div == 8'(M1_BASE_DIV - 1));
    assign m2_tick = (m2_div == 8'(M2_BASE_DIV - 1));

    // Free running prescale chain; each timer needs as many low bits clear as its exponent
    assign next_pre_cnt = pre_cnt + 16'h0001;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= 16'h0000;
        end else begin
            pre_cnt <= next_pre_cnt;
        end
    end

    // ========================================================================
    // Pin edge detection
    // ========================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= 5'h00;
            cap_q <= 1'b0;
            core_tl_q <= 1'b0;
            auxb_tl_q <= 1'b0;
            base_tl_q <= 1'b0;
        end else begin
            pin_q <= timer_input_pin_i;
            cap_q <= capture_input_pin_i;
            core_tl_q <= core_toggle_latch;
            auxb_tl_q <= auxb_toggle_latch;
            base_tl_q <= base_toggle_latch;
        end
    end
    assign pin_rise = timer_input_pin_i & ~pin_q;
    assign pin_fall = ~timer_input_pin_i & pin_q;
    // Edge select: 01 rise, 10 fall, 11 both; 00 none
    for (genvar i = 0; i < 5; i++) begin : g_ev
        assign pin_ev[i] = (ctl[i][F_EDGE_LO] & pin_rise[i])
                         | (ctl[i][F_EDGE_LO+1] & pin_fall[i]);
    end
    assign cap_ev = (ctl[4][F_EDGE_LO] & capture_input_pin_i & ~cap_q)
                  | (ctl[4][F_EDGE_LO+1] & ~capture_input_pin_i & cap_q);

    // ========================================================================
    // Count enables per timer
    // ========================================================================
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            logic tick;
            logic pre_hit;
            logic chain_ev;
            tick = (i < 3) ? m1_tick : m2_tick;
            pre_hit = tick && ((pre_cnt & ((16'h0001 << ctl[i][F_PRE_LO +: 3]) - 16'h0001))
                      == 16'h0000);
            // Aux timers clock from the partner toggle latch edge
            chain_ev = 1'b0;
            if (i == 0 || i == 2) begin
                chain_ev = core_toggle_latch ^ core_tl_q;
            end else if (i == 3) begin
                chain_ev = base_toggle_latch ^ base_tl_q;
            end
            inc[i] = 1'b0;
            if (ctl[i][F_RUN]) begin
                case (ctl[i][F_MODE_LO +: 3])
                    MODE_TIMER: inc[i] = pre_hit;
                    MODE_COUNT: inc[i] = pin_ev[i];
                    MODE_GATE: inc[i] = pre_hit && (timer_input_pin_i[i] == ctl[i][F_GATE_HI]) && (i < 3);
                    MODE_CHAIN: inc[i] = chain_ev && (i != 1) && (i != 4);
                    default: inc[i] = 1'b0;                       // Capture and unused modes stop
                    MODE_RELOAD: inc[i] = pre_hit && i == 4;
                endcase
            end
            // Software direction, optionally flipped by the pin
            down[i] = ctl[i][F_DOWN] ^ (ctl[i][F_EXTDIR] & direction_input_pin_i[i]);
        end
    end

    // ========================================================================
    // Loads: software writes, reloads, capture clear
    // ========================================================================
    logic core_rel_a;
    logic core_rel_b;
    logic core_tl_rise;
    logic core_tl_fall;
    assign core_tl_rise = core_toggle_latch & ~core_tl_q;
    assign core_tl_fall = ~core_toggle_latch & core_tl_q;
    // Reload by own pin event or chosen latch transition
    // Aux a on rise and aux b on fall makes continuous PWM
    assign core_rel_a = (ctl[0][F_MODE_LO +: 3] == MODE_RELOAD)
                      && (pin_ev[0] || (ctl[0][F_REL_LO] && core_tl_rise)
                          || (ctl[0][F_REL_LO+1] && core_tl_fall));
    assign core_rel_b = (ctl[2][F_MODE_LO +: 3] == MODE_RELOAD)
                      && (pin_ev[2] || (ctl[2][F_REL_LO] && core_tl_rise)
                          || (ctl[2][F_REL_LO+1] && core_tl_fall));

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            ld[i] = wb_wr && (adr_i == OFS_CNT_A + 8'(4 * i));
            ld_val[i] = wdat[15:0];
        end
        // Capture core value into aux timer on its pin
        if (ctl[0][F_MODE_LO +: 3] == MODE_CAPTURE && pin_ev[0]) begin
            ld[0] = 1'b1;
            ld_val[0] = cnt[1];
        end
        if (ctl[2][F_MODE_LO +: 3] == MODE_CAPTURE && pin_ev[2]) begin
            ld[2] = 1'b1;
            ld_val[2] = cnt[1];
        end
        if (core_rel_a) begin
            ld[1] = 1'b1;
            ld_val[1] = cnt[0];
        end else if (core_rel_b) begin
            ld[1] = 1'b1;
            ld_val[1] = cnt[2];
        end
        // Base timer reloads from the register on each wrap
        if (wrap[4] && ctl[4][F_MODE_LO +: 3] == MODE_RELOAD) begin
            ld[4] = 1'b1;
            ld_val[4] = capture_reload_reg;
        end
        // Second aux cleared right after capture if chosen
        if (cap_ev && ctl[3][F_CLR_S]) begin
            ld[3] = 1'b1;
            ld_val[3] = 16'h0000;
        end
    end

    // Five identical counters
    for (genvar i = 0; i < 5; i++) begin : g_tmr
        gptu_counter #(.W(16)) u_cnt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .inc_i(inc[i]),
            .down_i(down[i]),
            .load_i(ld[i]),
            .load_val_i(ld_val[i]),
            .count_o(cnt[i]),
            .wrap_o(wrap[i])
        );
    end

    // ========================================================================
    // Toggle latches and capture/reload register
    // ========================================================================
    // Latches invert on each wrap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_toggle_latch <= 1'b0;
            auxb_toggle_latch <= 1'b0;
            base_toggle_latch <= 1'b0;
        end else begin
            if (wrap[1]) core_toggle_latch <= ~core_toggle_latch;
            if (wrap[2]) auxb_toggle_latch <= ~auxb_toggle_latch;
            if (wrap[4]) base_toggle_latch <= ~base_toggle_latch;
        end
    end

    // Capture second aux value on capture pin edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_reload_reg <= CNT_RST;
        end else if (cap_ev) begin
            capture_reload_reg <= cnt[3];
        end else if (wb_wr && adr_i == OFS_CAPTURE_RELOAD_REG) begin
            capture_reload_reg <= wdat[15:0];
        end
    end

    // Toggle pins driven when enabled, low otherwise; capcom feed is wrap[4] ungated
    assign core_toggle_output_pin_o = core_toggle_latch & ctl[1][F_OUT_EN];
    assign auxb_toggle_output_pin_o = auxb_toggle_latch & ctl[2][F_OUT_EN];
    assign base_toggle_output_pin_o = base_toggle_latch & ctl[4][F_OUT_EN];
    assign capcom_clock_o = wrap[4];

    // ========================================================================
    // Interrupt flags
    // ========================================================================
    assign ev = {cap_ev, wrap};
    // Set beats write-one-to-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~((wb_wr && adr_i == OFS_STATUS) ? wdat[ST_W-1:0] : '0)) | ev;
        end
    end
    assign irq_o = |(status & mask);

    // ========================================================================
    // Wishbone slave
    // ========================================================================
    assign wb_req = cyc_i && stb_i && !ack_o;
    assign wb_wr = wb_req && we_i;
    // Byte lanes merge with the current value is skipped; low half needs sel[1:0]
    assign wdat = {sel_i[3] ? dat_i[31:24] : 8'h00, sel_i[2] ? dat_i[23:16] : 8'h00,
                   sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};

    // Control and mask registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 5; i++) ctl[i] <= CTL_RST;
            mask <= '0;
        end else if (wb_wr) begin
            for (int i = 0; i < 5; i++) begin
                if (adr_i == OFS_CTL_A + 8'(4 * i)) ctl[i] <= wdat[CTL_W-1:0];
            end
            if (adr_i == OFS_MASK) mask <= wdat[ST_W-1:0];
        end
    end

    // One answer, registered a cycle after the request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            dat_o <= 32'h0000_0000;
            if (wb_req && !we_i) begin
                for (int i = 0; i < 5; i++) begin
                    if (adr_i == OFS_CTL_A + 8'(4 * i)) dat_o <= {16'h0000, ctl[i]};
                    if (adr_i == OFS_CNT_A + 8'(4 * i)) dat_o <= {16'h0000, cnt[i]};
                end
                if (adr_i == OFS_CAPTURE_RELOAD_REG) dat_o <= {16'h0000, capture_reload_reg};
                if (adr_i == OFS_STATUS) dat_o <= {26'h0, status};
                if (adr_i == OFS_MASK) dat_o <= {26'h0, mask};
            end
        end
    end
endmodule : gptu_top

/* File: bench/gptu_monitor.sv */
// Checker for the timer unit: bus handshake, interrupt, base latch feed.
// Assumes it is bound to gptu_top and sees only that module's ports.
`timescale 1ns/1ps
module gptu_monitor
    import gptu_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Pins and interrupt
    input wire logic base_toggle_output_pin_o,
    input wire logic capcom_clock_o,
    input wire logic irq_o
);
    // ====================
    // Bus handshake
    // ====================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_due;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_due: assert property (p_ack_due) else $error("ack late");
    property p_ack_cause;
        ack_o |-> $past(cyc_i) && $past(stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    // Read data must not linger, a stale word could be taken as fresh
    property p_dat_idle;
        !ack_o |-> dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    property p_unmapped;
        ack_o && !we_i && adr_i > 8'h33 |-> dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    // ====================
    // Sticky requests
    // ====================
    property p_irq_fall;
        $fell(irq_o) |-> (ack_o && we_i) || ($past(ack_o) && $past(we_i));
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    property p_irq_stat;
        $past(irq_o) && ack_o && !we_i && adr_i == OFS_STATUS |-> dat_o[5:0] != 6'h0;
    endproperty
    a_irq_stat: assert property (p_irq_stat) else $error("irq, no status");
    // ====================
    // Base timer latch and feed
    // ====================
    property p_base_fall;
        capcom_clock_o && base_toggle_output_pin_o |=> !base_toggle_output_pin_o;
    endproperty
    a_base_fall: assert property (p_base_fall) else $error("latch kept");
    property p_base_rise;
        $rose(base_toggle_output_pin_o) |-> $past(capcom_clock_o) || ack_o || $past(ack_o);
    endproperty
    a_base_rise: assert property (p_base_rise) else $error("latch rose alone");
    property p_feed_pulse;
        capcom_clock_o |=> !capcom_clock_o;
    endproperty
    a_feed_pulse: assert property (p_feed_pulse) else $error("feed too long");
    c_irq: cover property (irq_o);
    c_irq_fall: cover property ($fell(irq_o));
    c_feed: cover property (capcom_clock_o);
endmodule : gptu_monitor

bind gptu_top gptu_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .base_toggle_output_pin_o, .capcom_clock_o, .irq_o);

/* File: bench/gptu_pin_model.sv */
// Model of the external gate, count, direction and capture pins.
// Assumes callers enter its tasks just after a rising clk_i edge.
`timescale 1ns/1ps
module gptu_pin_model (
    // Clock
    input wire logic clk_i,
    // Pins toward the timers
    output logic [4:0] timer_input_pin_o,
    output logic [4:0] direction_input_pin_o,
    output logic capture_input_pin_o
);
    // ====================
    // Levels start low so no stray edge follows reset
    // ====================
    initial begin
        timer_input_pin_o = 5'h00;
        direction_input_pin_o = 5'h00;
        capture_input_pin_o = 1'b0;
    end
    // Level change; index 5 is the capture pin
    task automatic set_lvl(input int i, input logic v);
        if (i == 5) begin
            capture_input_pin_o <= v;
        end else begin
            timer_input_pin_o[i] <= v;
        end
    endtask : set_lvl
    task automatic set_dir(input int i, input logic v);
        direction_input_pin_o[i] <= v;
    endtask : set_dir
    // Held 3 cycles each way so both edges stand apart
    task automatic pulse(input int i);
        set_lvl(i, 1'b1);
        repeat (3) @(posedge clk_i);
        set_lvl(i, 1'b0);
        repeat (3) @(posedge clk_i);
    endtask : pulse
endmodule : gptu_pin_model

/* File: bench/general_purpose_timer_unit_tb.sv */
// Self-checking bench for the timer unit: bus tasks and scenarios.
// Assumes gptu_top, the checker and the pin model are compiled first.
`timescale 1ns/1ps
module general_purpose_timer_unit_tb;
    import gptu_pkg::*;
    // ====================
    // Stimulus and results
    // ====================
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [4:0] tin;
    logic [4:0] din;
    logic cin;
    logic cpin;
    logic bpin;
    logic xpin;
    logic cc;
    logic irq;
    logic [31:0] rd;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 clk_i = ~clk_i;
    gptu_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .timer_input_pin_i(tin), .direction_input_pin_i(din),
        .capture_input_pin_i(cin), .core_toggle_output_pin_o(cpin),
        .auxb_toggle_output_pin_o(bpin), .base_toggle_output_pin_o(xpin),
        .capcom_clock_o(cc), .irq_o(irq));
    gptu_pin_model pins (.clk_i, .timer_input_pin_o(tin), .direction_input_pin_o(din),
        .capture_input_pin_o(cin));
    // ====================
    // Helpers
    // ====================
    function automatic logic [31:0] b(input int i);
        b = 32'h1 << i;
    endfunction : b
    function automatic logic [31:0] cw(input logic [2:0] m, input logic [31:0] x);
        cw = x | (32'(m) << F_MODE_LO) | b(F_RUN);
    endfunction : cw
    task automatic fail(input string m);
        fail_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail
    task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        check_count++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            fail($sformatf("got %h want %h..%h", g, lo, hi));
        end
    endtask : chk
    // Classic cycle held until ack; the global timeout ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        wb(1'b0, a, 32'h0);
        chk(rd, lo, hi);
    endtask : rdc
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    // Stop all timers and drop old requests
    task automatic idle();
        for (int a = 0; a <= 8'h10; a += 4) wr(8'(a), 32'h0);
        wr(OFS_STATUS, 32'h3f);
        wr(OFS_MASK, 32'h0);
    endtask : idle
    // ====================
    // Scenarios
    // ====================
    task automatic t_regs();
        for (int a = 0; a < 8'h3c; a += 4) rdc(8'(a), 0, 0);
        for (int a = 8'h14; a < 8'h2c; a += 4) begin
            wr(8'(a), 32'hffffffff);
            rdc(8'(a), 32'hffff, 32'hffff);
        end
        wr(8'h38, 32'hffffffff);
        rdc(8'h38, 0, 0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_rate();
        idle();
        wr(OFS_CNT_C, 0);
        wr(OFS_CNT_T, 0);
        wr(OFS_CTL_C, cw(MODE_TIMER, 0));
        wr(OFS_CTL_T, cw(MODE_TIMER, 0));
        wt(80);
        rdc(OFS_CNT_C, 9, 12);
        rdc(OFS_CNT_T, 19, 24);
        pins.set_dir(1, 1'b1);
        wr(OFS_CNT_C, 32'h100);
        wr(OFS_CTL_C, cw(MODE_TIMER, b(F_EXTDIR)));
        wt(80);
        rdc(OFS_CNT_C, 32'hf3, 32'hf8);
        pins.set_dir(1, 1'b0);
        $display("t_rate done");
    endtask : t_rate
    task automatic t_wrap();
        idle();
        wr(OFS_CNT_C, 0);
        wr(OFS_CNT_B, 0);
        wr(OFS_CTL_C, cw(MODE_TIMER, b(F_DOWN) | b(F_OUT_EN)));
        wr(OFS_CTL_B, cw(MODE_TIMER, b(F_DOWN) | b(F_OUT_EN)));
        wt(20);
        chk(irq, 0, 0);
        chk({cpin, bpin}, 3, 3);
        rdc(OFS_STATUS, 6, 6);
        wr(OFS_MASK, b(ST_C));
        chk(irq, 1, 1);
        wr(OFS_STATUS, b(ST_C));
        chk(irq, 0, 0);
        rdc(OFS_STATUS, 4, 4);
        $display("t_wrap done");
    endtask : t_wrap
    task automatic t_modes();
        idle();
        wr(OFS_CNT_A, 0);
        wr(OFS_CTL_A, cw(MODE_COUNT, 32'h3 << F_EDGE_LO));
        repeat (3) pins.pulse(0);
        rdc(OFS_CNT_A, 6, 6);
        wr(OFS_CNT_B, 0);
        wr(OFS_CTL_B, cw(MODE_GATE, b(F_GATE_HI)));
        wt(40);
        rdc(OFS_CNT_B, 0, 0);
        pins.set_lvl(2, 1'b1);
        wt(80);
        rdc(OFS_CNT_B, 9, 12);
        pins.set_lvl(2, 1'b0);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_capload();
        idle();
        wr(OFS_CNT_C, 32'h100);
        wr(OFS_CTL_C, cw(MODE_TIMER, 0));
        wr(OFS_CTL_A, cw(MODE_CAPTURE, b(F_EDGE_LO)));
        wt(40);
        pins.set_lvl(0, 1'b1);
        wt(4);
        rdc(OFS_CNT_A, 32'h104, 32'h108);
        wt(40);
        rdc(OFS_CNT_A, rd, rd);
        pins.set_lvl(0, 1'b0);
        wr(OFS_CNT_A, 32'h1234);
        wr(OFS_CTL_A, cw(MODE_RELOAD, 32'h3 << F_EDGE_LO));
        pins.set_lvl(0, 1'b1);
        wt(4);
        rdc(OFS_CNT_C, 32'h1234, 32'h1236);
        rdc(OFS_CNT_A, 32'h1234, 32'h1234);
        pins.set_lvl(0, 1'b0);
        $display("t_capload done");
    endtask : t_capload
    // Without both reloads the latch would toggle once in this span
    task automatic t_pwm();
        int n;
        logic p;
        idle();
        wr(OFS_CNT_A, 32'hfffc);
        wr(OFS_CNT_B, 32'hfffa);
        wr(OFS_CTL_A, cw(MODE_RELOAD, b(F_REL_LO)));
        wr(OFS_CTL_B, cw(MODE_RELOAD, b(F_REL_LO + 1)));
        wr(OFS_CNT_C, 32'hfff0);
        wr(OFS_CTL_C, cw(MODE_TIMER, b(F_OUT_EN)));
        n = 0;
        p = cpin;
        repeat (600) begin
            @(posedge clk_i);
            n += (cpin !== p);
            p = cpin;
        end
        chk(n, 8, 40);
        $display("t_pwm done");
    endtask : t_pwm
    task automatic t_mod2();
        int n;
        idle();
        wr(OFS_CAPTURE_RELOAD_REG, 32'hfff8);
        wr(OFS_CNT_T, 32'hfffc);
        wr(OFS_CNT_S, 0);
        wr(OFS_CTL_S, cw(MODE_CHAIN, 32'h3 << F_EDGE_LO));
        wr(OFS_CTL_T, cw(MODE_RELOAD, b(F_OUT_EN)));
        n = 0;
        repeat (200) begin
            @(posedge clk_i);
            n += (cc === 1'b1);
        end
        chk(n, 5, 7);
        rdc(OFS_CNT_T, 32'hfff8, 32'hffff);
        rdc(OFS_CNT_S, 2, 7);
        rdc(OFS_STATUS, b(ST_T), b(ST_T));
        idle();
        wr(OFS_CNT_S, 0);
        wr(OFS_CTL_T, 32'h3 << F_EDGE_LO);
        wr(OFS_CTL_S, cw(MODE_TIMER, b(F_CLR_S)));
        wt(80);
        pins.set_lvl(5, 1'b1);
        wt(4);
        rdc(OFS_CAPTURE_RELOAD_REG, 18, 23);
        rdc(OFS_CNT_S, 0, 3);
        rdc(OFS_STATUS, b(ST_CR), b(ST_CR));
        $display("t_mod2 done");
    endtask : t_mod2
    // ====================
    // Verdict and hang guard
    // ====================
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // Whole run needs about 1700 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_rate();
        t_wrap();
        t_modes();
        t_capload();
        t_pwm();
        t_mod2();
        end_of_test();
    end
endmodule : general_purpose_timer_unit_tb
